// ---- include/tmr_pkg.sv ----
// Constants and types for the 16-bit timer/counter
package tmr_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOW = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_ENABLES = 8'h10;
    localparam logic [7:0] OFS_PRIORITY = 8'h14;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam int OVF_BIT = 1;
    localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Instruction clock is the core clock divided by four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    typedef enum {
        SEL_CTRL, SEL_LOW, SEL_HIGH, SEL_FLAGS,
        SEL_ENABLES, SEL_PRIORITY, SEL_NONE
    } reg_sel_t;

    typedef struct packed {
        logic wide_access_mode;
        logic tb_sel_hi;
        logic [1:0] input_prescale_select;
        logic tb_sel_lo;
        logic ext_sync_bypass;
        logic count_source_select;
        logic counter_run;
    } timer_control_t;

    typedef struct packed {
        logic [1:0] event_trigger;
        logic [3:0] unit1_mode;
        logic [3:0] unit2_mode;
    } compare_in_t;

    typedef struct packed {
        logic unit1_uses_this;
        logic unit2_uses_this;
    } timebase_out_t;
endpackage

// ---- rtl/timer16.sv ----
// 16-bit timer/counter with AXI4-Lite register access
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Control bit 7 selects buffered 16-bit access, else two plain byte accesses.
// R2 - Timebase field bits 6,3: 1x both units, 01 second unit only, 00 none.
// R3 - Prescale bits 5-4: 11 8, 10 4, 01 2, 00 1.
// R4 - External source: bit 2 set bypasses sync, clear synchronises; ignored internally.
// R5 - Bit 1 clear counts instruction clock; set counts edges after first fall.
// R6 - Bit 0 set lets the counter advance; clear holds it stopped.
// R7 - Modes timer, sync counter, async counter from source and sync bits.
// R8 - Companion oscillator on: shared pins are inputs and read as zero.
// R9 - Wide mode: low-byte read copies live high byte into buffer.
// R10 - Wide mode: high writes hit buffer; low write loads both bytes.
// R11 - High-byte writes keep prescaler; only low-byte writes clear it.
// R12 - Companion oscillator drives the count when enabled and source bit set.
// R13 - Counter counts 0000h up to FFFFh then wraps to 0000h.
// R14 - Wrap sets overflow flag; request raised only when its enable is set.
// R15 - Special-event trigger from a unit using this timer resets counter.
// R16 - Special-event reset is not guaranteed in asynchronous counter mode.
// R17 - A counter write in the trigger cycle wins over the reset.
// R18 - Special-event resets never set the overflow flag.
// R19 - Overflow flag holds until software writes zero to it.
// R20 - Byte mode reads and writes the live counter bytes directly.
module timer16 (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_count_pin,
    input wire logic companion_osc_clk,
    input wire logic companion_osc_enable,
    input wire logic [1:0] port_direction_bits,
    input wire logic [1:0] shared_pin_in,
    output logic [1:0] shared_pin_oe,
    output logic [1:0] shared_pin_read,
    input wire tmr_pkg::compare_in_t compare_in,
    output tmr_pkg::timebase_out_t timebase_out,
    output logic overflow_irq
);
    function automatic tmr_pkg::reg_sel_t reg_sel(
        input logic [7:0] a);
        tmr_pkg::reg_sel_t s;
        s = tmr_pkg::SEL_NONE;
        unique case (a)
            tmr_pkg::OFS_CTRL: s = tmr_pkg::SEL_CTRL;
            tmr_pkg::OFS_LOW: s = tmr_pkg::SEL_LOW;
            tmr_pkg::OFS_HIGH: s = tmr_pkg::SEL_HIGH;
            tmr_pkg::OFS_FLAGS: s = tmr_pkg::SEL_FLAGS;
            tmr_pkg::OFS_ENABLES: s = tmr_pkg::SEL_ENABLES;
            tmr_pkg::OFS_PRIORITY: s = tmr_pkg::SEL_PRIORITY;
            default: s = tmr_pkg::SEL_NONE;
        endcase
        return s;
    endfunction

    function automatic logic [2:0] presc_last(input logic [1:0] code);
        logic [2:0] v;
        v = 3'h0;
        unique case (code)
            2'h0: v = 3'h0;
            2'h1: v = 3'h1;
            2'h2: v = 3'h3;
            2'h3: v = 3'h7;
        endcase
        return v;
    endfunction

    tmr_pkg::timer_control_t ctrl_r;
    logic [15:0] count_r;
    logic [7:0] hbuf_r;
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic [7:0] priority_r;
    logic wr_rdy_r;
    logic rd_rdy_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [1:0] div_r;
    logic [2:0] ps_r;
    logic sync1_r;
    logic sync2_r;
    logic raw_r;
    logic prev_r;
    logic armed_r;
    logic [1:0] pin_oe_r;
    logic [1:0] pin_rd_r;
    tmr_pkg::timebase_out_t tb_r;
    logic irq_r;

    logic wr_fire;
    logic rd_fire;
    tmr_pkg::reg_sel_t wsel;
    tmr_pkg::reg_sel_t rsel;
    logic [7:0] wbyte;
    logic wlane;
    logic wr_low;
    logic wr_high;
    logic wr_count;
    logic instr_en;
    logic src_level;
    logic sample;
    logic ext_edge;
    logic count_in;
    logic tick;
    logic async_mode;
    logic [1:0] uses_this;
    logic trig_hit;
    logic wrap;

    // Bus handshake
    assign wr_fire = s_axi_awvalid & wr_rdy_r & s_axi_wvalid;
    assign rd_fire = s_axi_arvalid & rd_rdy_r;
    assign wsel = reg_sel(s_axi_awaddr);
    assign rsel = reg_sel(s_axi_araddr);
    assign wbyte = s_axi_wdata[7:0];
    assign wlane = s_axi_wstrb[0];
    assign wr_low = wr_fire & wlane & (wsel == tmr_pkg::SEL_LOW);
    assign wr_high = wr_fire & wlane & (wsel == tmr_pkg::SEL_HIGH);
    assign wr_count = wr_low | (wr_high & ~ctrl_r.wide_access_mode);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_rdy_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= tmr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            wr_rdy_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (wsel == tmr_pkg::SEL_NONE) ?
                tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
        end else begin
            wr_rdy_r <= s_axi_awvalid & s_axi_wvalid & ~bvalid_r
                & ~wr_rdy_r;
            if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= tmr_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (rd_fire) begin
            rd_rdy_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= tmr_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            unique case (rsel)
                tmr_pkg::SEL_CTRL: rdata_r[7:0] <= ctrl_r;
                tmr_pkg::SEL_LOW: rdata_r[7:0] <= count_r[7:0];
                tmr_pkg::SEL_HIGH: begin
                    rdata_r[7:0] <= ctrl_r.wide_access_mode ?
                        hbuf_r : count_r[15:8]; // see R9 see R20
                end
                tmr_pkg::SEL_FLAGS: rdata_r[7:0] <= flags_r;
                tmr_pkg::SEL_ENABLES: rdata_r[7:0] <= enables_r;
                tmr_pkg::SEL_PRIORITY: rdata_r[7:0] <= priority_r;
                tmr_pkg::SEL_NONE: rresp_r <= tmr_pkg::RESP_SLVERR;
            endcase
        end else begin
            rd_rdy_r <= s_axi_arvalid & ~rvalid_r & ~rd_rdy_r;
            if (rvalid_r & s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Plain storage registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= tmr_pkg::CTRL_RESET;
            enables_r <= tmr_pkg::BYTE_RESET;
            priority_r <= tmr_pkg::BYTE_RESET;
        end else if (wr_fire & wlane) begin
            if (wsel == tmr_pkg::SEL_CTRL) begin
                ctrl_r <= wbyte;
            end
            if (wsel == tmr_pkg::SEL_ENABLES) begin
                enables_r <= wbyte;
            end
            if (wsel == tmr_pkg::SEL_PRIORITY) begin
                priority_r <= wbyte;
            end
        end
    end

    // High-byte buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hbuf_r <= tmr_pkg::BYTE_RESET;
        end else if (ctrl_r.wide_access_mode) begin // see R1
            if (wr_high) begin
                hbuf_r <= wbyte; // see R10
            end else if (rd_fire & (rsel == tmr_pkg::SEL_LOW)) begin
                hbuf_r <= count_r[15:8]; // see R9
            end
        end
    end

    // Count source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign instr_en = (div_r == tmr_pkg::INSTR_DIV_LAST);

    // Companion oscillator replaces the pin when enabled
    assign src_level = companion_osc_enable ?
        companion_osc_clk : external_count_pin; // see R12

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            raw_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= src_level;
            sync2_r <= sync1_r;
            raw_r <= src_level;
            prev_r <= sample;
        end
    end
    // Bypass path has one flop less latency
    assign sample = ctrl_r.ext_sync_bypass ? raw_r : sync2_r; // see R4

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (!ctrl_r.count_source_select) begin
            armed_r <= 1'b0;
        end else if (prev_r & ~sample) begin
            armed_r <= 1'b1; // see R5
        end
    end
    assign ext_edge = armed_r & sample & ~prev_r; // see R5
    assign count_in = ctrl_r.count_source_select ?
        ext_edge : instr_en; // see R5 see R7

    // Prescaler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ps_r <= 3'h0;
        end else if (wr_low) begin
            ps_r <= 3'h0; // see R11
        end else if (ctrl_r.counter_run & count_in) begin
            if (ps_r >= presc_last(ctrl_r.input_prescale_select)) begin
                ps_r <= 3'h0; // see R3
            end else begin
                ps_r <= ps_r + 3'h1;
            end
        end
    end
    assign tick = ctrl_r.counter_run & count_in
        & (ps_r >= presc_last(ctrl_r.input_prescale_select)); // see R3 see R6

    // Timebase selection and special event
    assign uses_this[0] = ctrl_r.tb_sel_hi; // see R2
    assign uses_this[1] = ctrl_r.tb_sel_hi | ctrl_r.tb_sel_lo; // see R2
    assign async_mode = ctrl_r.count_source_select
        & ctrl_r.ext_sync_bypass; // see R7
    assign trig_hit = ~async_mode & ( // see R16
        (compare_in.event_trigger[0] & uses_this[0]
         & (compare_in.unit1_mode == tmr_pkg::SPECIAL_EVENT_MODE))
        | (compare_in.event_trigger[1] & uses_this[1]
         & (compare_in.unit2_mode == tmr_pkg::SPECIAL_EVENT_MODE)));
    assign wrap = tick & (count_r == tmr_pkg::COUNT_MAX);

    // Counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= tmr_pkg::COUNT_RESET;
        end else if (wr_count) begin // see R17
            if (wr_low) begin
                count_r[7:0] <= wbyte;
                if (ctrl_r.wide_access_mode) begin
                    count_r[15:8] <= hbuf_r; // see R10
                end
            end else begin
                count_r[15:8] <= wbyte; // see R20
            end
        end else if (trig_hit) begin
            count_r <= tmr_pkg::COUNT_RESET; // see R15
        end else if (tick) begin
            count_r <= count_r + 16'h0001; // see R13
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r <= tmr_pkg::BYTE_RESET;
        end else begin
            if (wr_fire & wlane & (wsel == tmr_pkg::SEL_FLAGS)) begin
                flags_r <= wbyte & flags_r; // see R19
            end
            if (wrap & ~wr_count & ~trig_hit) begin
                flags_r[tmr_pkg::OVF_BIT] <= 1'b1; // see R14 see R18
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
            tb_r <= '0;
        end else begin
            irq_r <= flags_r[tmr_pkg::OVF_BIT]
                & enables_r[tmr_pkg::OVF_BIT]; // see R14
            tb_r.unit1_uses_this <= uses_this[0];
            tb_r.unit2_uses_this <= uses_this[1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_oe_r <= 2'h0;
            pin_rd_r <= 2'h0;
        end else if (companion_osc_enable) begin
            pin_oe_r <= 2'h0; // see R8
            pin_rd_r <= 2'h0;
        end else begin
            pin_oe_r <= ~port_direction_bits;
            pin_rd_r <= shared_pin_in;
        end
    end

    assign s_axi_awready = wr_rdy_r;
    assign s_axi_wready = wr_rdy_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = rd_rdy_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign shared_pin_oe = pin_oe_r;
    assign shared_pin_read = pin_rd_r;
    assign timebase_out = tb_r;
    assign overflow_irq = irq_r;

    // Checks
    sequence s_low_read_wide;
        rd_fire && rsel == tmr_pkg::SEL_LOW && ctrl_r.wide_access_mode;
    endsequence
    sequence s_buf_holds(logic [7:0] v);
        hbuf_r == v;
    endsequence

    a_wrap_to_zero: assert property ( // see R13
        @(posedge clk) disable iff (rst)
        wrap && !wr_count && !trig_hit |=> count_r == tmr_pkg::COUNT_RESET)
        else $error("counter did not wrap to zero");

    a_ovf_on_wrap: assert property ( // see R14
        @(posedge clk) disable iff (rst)
        wrap && !wr_count && !trig_hit |=> flags_r[tmr_pkg::OVF_BIT])
        else $error("overflow flag not set on wrap");

    a_trig_reset: assert property ( // see R15
        @(posedge clk) disable iff (rst)
        trig_hit && !wr_count |=> count_r == tmr_pkg::COUNT_RESET
        && !$rose(flags_r[tmr_pkg::OVF_BIT]))
        else $error("trigger reset wrong");

    a_write_wins: assert property ( // see R17
        @(posedge clk) disable iff (rst)
        wr_low && !ctrl_r.wide_access_mode |=>
        count_r[7:0] == $past(wbyte))
        else $error("write lost to trigger");

    a_flag_sticky: assert property ( // see R19
        @(posedge clk) disable iff (rst)
        flags_r[tmr_pkg::OVF_BIT] && !(wr_fire
        && wsel == tmr_pkg::SEL_FLAGS) |=> flags_r[tmr_pkg::OVF_BIT])
        else $error("overflow flag cleared by itself");

    a_stop_holds: assert property ( // see R6
        @(posedge clk) disable iff (rst)
        !ctrl_r.counter_run && !wr_count && !trig_hit
        |=> $stable(count_r))
        else $error("stopped counter moved");

    a_buf_low_read: assert property ( // see R9
        @(posedge clk) disable iff (rst)
        s_low_read_wide ##0 !wr_high
        |=> s_buf_holds($past(count_r[15:8])))
        else $error("buffer not loaded on low read");

    a_high_wr_presc: assert property ( // see R11
        @(posedge clk) disable iff (rst)
        wr_high && !count_in |=> ps_r == $past(ps_r))
        else $error("high write disturbed prescaler");

    a_irq_gate: assert property ( // see R14
        @(posedge clk) disable iff (rst)
        !enables_r[tmr_pkg::OVF_BIT] ##1
        !enables_r[tmr_pkg::OVF_BIT] |-> !overflow_irq)
        else $error("request raised while disabled");

    a_pins_osc: assert property ( // see R8
        @(posedge clk) disable iff (rst)
        companion_osc_enable |=> shared_pin_oe == 2'h0
        && shared_pin_read == 2'h0)
        else $error("shared pins not released");
endmodule

// ---- tb/cmp_partner.sv ----
// Model of the compare units and the external count sources
`timescale 1ns/10ps
module cmp_partner (
    input wire logic clk,
    output logic external_count_pin,
    output logic companion_osc_clk,
    output tmr_pkg::compare_in_t compare_in
);
    initial begin
        external_count_pin = 1'b1;
        companion_osc_clk = 1'b1;
        compare_in = '0;
    end

    // One-cycle trigger from a unit in the given mode
    task automatic fire(input int unit, input logic [3:0] mode);
        @(posedge clk);
        compare_in.unit1_mode <= mode;
        compare_in.unit2_mode <= mode;
        @(posedge clk);
        compare_in.event_trigger[unit] <= 1'b1;
        @(posedge clk);
        compare_in.event_trigger <= 2'b00;
    endtask

    // Falling edge first, then n rising edges; source stands high after
    task automatic edges(input int n, input bit use_osc);
        for (int i = 0; i < n; i++) begin
            if (use_osc) companion_osc_clk <= 1'b0;
            else external_count_pin <= 1'b0;
            repeat (8) @(posedge clk);
            if (use_osc) companion_osc_clk <= 1'b1;
            else external_count_pin <= 1'b1;
            repeat (8) @(posedge clk);
        end
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, overflow_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, shared_pin_oe, shared_pin_read;
    logic [31:0] s_axi_rdata;
    logic companion_osc_enable = 1'b0;
    logic [1:0] port_direction_bits = 2'h0, shared_pin_in = 2'h0;
    logic external_count_pin, companion_osc_clk;
    tmr_pkg::compare_in_t compare_in;
    tmr_pkg::timebase_out_t timebase_out;
    int fails = 0, cmp_count = 0, cyc = 0;
    logic [1:0] last_resp;
    logic [7:0] rv, lo, hi, v;

    always #5 clk = ~clk;

    timer16 u_timer16 (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .external_count_pin(external_count_pin),
        .companion_osc_clk(companion_osc_clk),
        .companion_osc_enable(companion_osc_enable),
        .port_direction_bits(port_direction_bits),
        .shared_pin_in(shared_pin_in), .shared_pin_oe(shared_pin_oe),
        .shared_pin_read(shared_pin_read), .compare_in(compare_in),
        .timebase_out(timebase_out), .overflow_irq(overflow_irq));

    cmp_partner u_cmp_partner (.clk(clk),
        .external_count_pin(external_count_pin),
        .companion_osc_clk(companion_osc_clk), .compare_in(compare_in));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] mn,
                           input logic [15:0] mx, input string m);
        cmp_count++;
        if ($isunknown(got) || got < mn || got > mx) begin
            fails++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata[7:0];
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Byte-mode load of the full count, low write also clears prescaler
    task automatic set_count(input logic [15:0] c);
        axi_wr(tmr_pkg::OFS_HIGH, c[15:8]);
        axi_wr(tmr_pkg::OFS_LOW, c[7:0]);
    endtask

    task automatic get_count(output logic [15:0] c);
        axi_rd(tmr_pkg::OFS_LOW, c[7:0]);
        axi_rd(tmr_pkg::OFS_HIGH, c[15:8]);
    endtask

    function automatic logic [1:0] exp_tb(input logic [1:0] code);
        return code[1] ? 2'b11 : (code[0] ? 2'b01 : 2'b00);
    endfunction

    function automatic logic [7:0] tb_ctrl(input logic [1:0] code);
        return {1'b0, code[1], 2'b00, code[0], 3'b000};
    endfunction

    logic [15:0] cnt;
    logic [1:0] ecode [6] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b11, 2'b10};
    int eunit [6] = '{0, 1, 0, 1, 0, 0};
    logic [3:0] emode [6] = '{4'hB, 4'hB, 4'hB, 4'hB, 4'hA, 4'hB};
    bit ehit [6] = '{1, 1, 0, 1, 0, 0};
    // Last case runs as asynchronous counter, where the reset is dropped
    logic [7:0] eextra [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06};

    initial begin
        void'($urandom(25));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        axi_rd(tmr_pkg::OFS_CTRL, rv);
        chk(rv, tmr_pkg::CTRL_RESET, "control reset");
        axi_rd(8'h20, rv);
        chk(last_resp, tmr_pkg::RESP_SLVERR, "unmapped read");
        axi_wr(8'h20, 8'h5A);
        chk(last_resp, tmr_pkg::RESP_SLVERR, "unmapped write");
        for (int c = 0; c < 4; c++) begin
            axi_wr(tmr_pkg::OFS_CTRL, tb_ctrl(c[1:0]));
            repeat (2) @(posedge clk);
            chk(timebase_out, exp_tb(c[1:0]), "timebase");
        end
        $display("test timebase done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom()) & 8'hFE;
            axi_wr(tmr_pkg::OFS_CTRL, v);
            axi_rd(tmr_pkg::OFS_CTRL, rv);
            chk(rv, v, "control storage");
            axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
            lo = 8'($urandom());
            hi = 8'($urandom());
            set_count({hi, lo});
            get_count(cnt);
            chk(cnt, {hi, lo}, "byte mode count");
            axi_wr(tmr_pkg::OFS_CTRL, 8'h80);
            axi_wr(tmr_pkg::OFS_HIGH, ~hi);
            axi_wr(tmr_pkg::OFS_LOW, lo ^ 8'h0F);
            axi_wr(tmr_pkg::OFS_HIGH, hi);
            get_count(cnt);
            chk(cnt, {~hi, lo ^ 8'h0F}, "wide read pair");
            axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
            axi_rd(tmr_pkg::OFS_HIGH, rv);
            chk(rv, 8'(~hi), "wide high write buffered");
        end
        $display("test access modes done");
        for (int p = 0; p < 4; p++) begin
            set_count(16'h0000);
            axi_wr(tmr_pkg::OFS_CTRL, {2'b00, p[1:0], 4'b0001});
            repeat (400) @(posedge clk);
            axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
            get_count(cnt);
            chk_rng(cnt, (16'd100 >> p) - 2, (16'd100 >> p) + 2,
                    "prescale rate");
            {hi, lo} = cnt;
            repeat (30) @(posedge clk);
            get_count(cnt);
            chk(cnt, {hi, lo}, "stopped holds");
        end
        $display("test prescale done");
        axi_wr(tmr_pkg::OFS_ENABLES, 8'h02);
        set_count(16'hFFF0);
        axi_wr(tmr_pkg::OFS_CTRL, 8'h01);
        repeat (100) @(posedge clk);
        axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
        get_count(cnt);
        chk_rng(cnt, 16'h0001, 16'h0010, "wrap to zero");
        axi_rd(tmr_pkg::OFS_FLAGS, rv);
        chk(rv, 8'h02, "overflow flag");
        repeat (50) @(posedge clk);
        axi_rd(tmr_pkg::OFS_FLAGS, rv);
        chk(rv, 8'h02, "flag holds");
        chk(overflow_irq, 1'b1, "irq enabled");
        axi_wr(tmr_pkg::OFS_ENABLES, 8'h00);
        repeat (2) @(posedge clk);
        chk(overflow_irq, 1'b0, "irq masked");
        axi_wr(tmr_pkg::OFS_FLAGS, 8'h00);
        axi_rd(tmr_pkg::OFS_FLAGS, rv);
        chk(rv, 8'h00, "flag cleared");
        $display("test overflow done");
        for (int k = 0; k < 6; k++) begin
            axi_wr(tmr_pkg::OFS_CTRL, tb_ctrl(ecode[k]) | eextra[k]);
            set_count(16'h1234);
            axi_wr(tmr_pkg::OFS_CTRL, tb_ctrl(ecode[k]) | eextra[k] | 8'h01);
            u_cmp_partner.fire(eunit[k], emode[k]);
            axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
            get_count(cnt);
            if (ehit[k]) chk_rng(cnt, 16'h0000, 16'h0004, "event reset");
            else chk_rng(cnt, 16'h1234, 16'h1240, "event ignored");
            axi_rd(tmr_pkg::OFS_FLAGS, rv);
            chk(rv, 8'h00, "event no flag");
        end
        $display("test special event done");
        for (int m = 0; m < 3; m++) begin
            companion_osc_enable <= (m == 2);
            port_direction_bits <= 2'($urandom());
            shared_pin_in <= 2'($urandom());
            set_count(16'h0000);
            axi_wr(tmr_pkg::OFS_CTRL, (m == 1) ? 8'h07 : 8'h03);
            u_cmp_partner.edges(7 + m, m == 2);
            repeat (10) @(posedge clk);
            axi_wr(tmr_pkg::OFS_CTRL, 8'h00);
            get_count(cnt);
            chk(cnt, 16'(7 + m), "external count");
            chk(shared_pin_oe, (m == 2) ? 2'b00 : 2'(~port_direction_bits),
                "pin direction");
            chk(shared_pin_read, (m == 2) ? 2'b00 : shared_pin_in,
                "pin read");
        end
        $display("test external source done");
        complete_run();
    end
endmodule
